// *** logic/ris_pkg.sv ***
// package: register offsets, field positions, reset values and timing of the radio interrupt block
package ris_pkg;
  localparam logic [6:0] RIS_OFS_STATUS_ONE   = 7'h03;
  localparam logic [6:0] RIS_OFS_STATUS_TWO   = 7'h04;
  localparam logic [6:0] RIS_OFS_ENABLE_ONE   = 7'h05;
  localparam logic [6:0] RIS_OFS_ENABLE_TWO   = 7'h06;
  // second-group field positions
  localparam int RIS_B_SYNC    = 7;
  localparam int RIS_B_PRE_OK  = 6;
  localparam int RIS_B_PRE_BAD = 5;
  localparam int RIS_B_RSSI    = 4;
  localparam int RIS_B_WAKE    = 3;
  localparam int RIS_B_LOWBAT  = 2;
  localparam int RIS_B_READY   = 1;
  localparam int RIS_B_POR     = 0;
  // first-group field positions
  localparam int RIS_B_FIFO_ERR  = 7;
  localparam int RIS_B_TX_AFULL  = 6;
  localparam int RIS_B_TX_AEMPTY = 5;
  localparam int RIS_B_RX_AFULL  = 4;
  localparam int RIS_B_EXT       = 3;
  localparam int RIS_B_PK_SENT   = 2;
  localparam int RIS_B_PK_VALID  = 1;
  localparam int RIS_B_CRC_ERR   = 0;
  // writable part of the second enable register
  localparam logic [7:0] RIS_EN_TWO_WMASK = 8'h1f;
  localparam logic [7:0] RIS_EN_ONE_RST   = 8'h00;
  localparam logic [7:0] RIS_EN_TWO_RST   = 8'h00;
  localparam logic [7:0] RIS_STATUS_RST   = 8'h01;
  // crystal settling time
  localparam int RIS_XTAL_SETTLE_US = 600;
  localparam int RIS_CLK_MHZ        = 10;
  localparam int RIS_XTAL_SETTLE_CYC = RIS_XTAL_SETTLE_US * RIS_CLK_MHZ;
  typedef enum logic [1:0] {RIS_XT_IDLE, RIS_XT_SETTLE, RIS_XT_READY} ris_xtal_e;
endpackage

// *** logic/ris_settle.sv ***
// crystal settle timer: flags ready after the settling count while any clock user is on
`timescale 1ns/1ps
module ris_settle #(
  parameter int SETTLE_CYC = ris_pkg::RIS_XTAL_SETTLE_CYC
) (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic xtal_on_i,
  output logic      ready_o
);
  import ris_pkg::*;
  ris_xtal_e   state;
  ris_xtal_e   next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  // count down while settling; dropping the request returns to idle from any state
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      RIS_XT_IDLE: begin
        next_cnt = 16'(SETTLE_CYC - 1);
        if (xtal_on_i) next_state = RIS_XT_SETTLE;
      end
      RIS_XT_SETTLE: begin
        if (!xtal_on_i) next_state = RIS_XT_IDLE;
        else if (cnt == 16'h0000) next_state = RIS_XT_READY;
        else next_cnt = cnt - 16'h0001;
      end
      RIS_XT_READY: begin
        if (!xtal_on_i) next_state = RIS_XT_IDLE;
      end
      default: next_state = RIS_XT_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= RIS_XT_IDLE;
      cnt   <= 16'h0000;
    end else if (ce_i) begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign ready_o = (state == RIS_XT_READY);
endmodule

// *** logic/ris_edge.sv ***
// rising edge detector for a group of event levels
`timescale 1ns/1ps
module ris_edge #(
  parameter int W = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] lvl_i,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] prev;
  logic [W-1:0] next_prev;

  // previous level, so a held level gives only one pulse
  always_comb begin
    next_prev = lvl_i;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) prev <= '0;
    else if (ce_i) prev <= next_prev;
  end

  assign rise_o = lvl_i & ~prev;
endmodule

// *** logic/ris_irq.sv ***
// radio interrupt status and enable registers with the active-low interrupt pin
`timescale 1ns/1ps
module ris_irq #(
  parameter int SETTLE_CYC = ris_pkg::RIS_XTAL_SETTLE_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       pre_det_mode_i,
  input  wire logic       sync_det_i,
  input  wire logic       pkt_done_i,
  input  wire logic       pre_det_i,
  input  wire logic       sync_timeout_i,
  input  wire logic       pre_bad_i,
  input  wire logic       rssi_above_i,
  input  wire logic       wake_expire_i,
  input  wire logic       lowbat_i,
  input  wire logic       xtal_on_i,
  input  wire logic       por_i,
  input  wire logic [7:0] group_one_evt_i,
  output logic            interrupt_request_low_o
);
  import ris_pkg::*;

  logic [7:0] en_one;
  logic [7:0] next_en_one;
  logic [7:0] en_two_w;
  logic [7:0] next_en_two_w;
  logic [7:0] en_two;
  logic [7:0] st_two;
  logic [7:0] next_st_two;
  logic [7:0] st_one;
  logic [7:0] next_st_one;
  logic [7:0] pend_two;
  logic [7:0] next_pend_two;
  logic [7:0] rise_two;
  logic [7:0] rise_one;
  logic [7:0] src_two;
  logic       chip_ready;
  logic       rd_two;
  logic       rd_one;
  logic       irq_low;
  logic       next_irq_low;
  logic [7:0] next_rdata;
  logic       pend_any;

  ris_settle #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_settle (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .xtal_on_i (xtal_on_i),
    .ready_o   (chip_ready)
  );

  ris_edge #(.W(8)) u_edge_two (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .ce_i   (ce_i),
    .lvl_i  (st_two),
    .rise_o (rise_two)
  );

  ris_edge #(.W(8)) u_edge_one (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .ce_i   (ce_i),
    .lvl_i  (group_one_evt_i),
    .rise_o (rise_one)
  );

  assign rd_two = ce_i & reg_rd_i & (reg_addr_i == RIS_OFS_STATUS_TWO);
  assign rd_one = ce_i & reg_rd_i & (reg_addr_i == RIS_OFS_STATUS_ONE);

  // top three enables mirror the preamble detect mode, never the host write
  assign en_two = {{3{pre_det_mode_i}}, en_two_w[4:0]};

  // enable registers; only writable bits of the second one are stored
  always_comb begin
    next_en_one   = en_one;
    next_en_two_w = en_two_w;
    if (ce_i && reg_wr_i && reg_addr_i == RIS_OFS_ENABLE_ONE) begin
      next_en_one = reg_wdata_i;
    end
    if (ce_i && reg_wr_i && reg_addr_i == RIS_OFS_ENABLE_TWO) begin
      next_en_two_w = reg_wdata_i & RIS_EN_TWO_WMASK;
    end
  end

  // second-group status levels, as the radio sees them
  always_comb begin
    next_st_two = st_two;
    if (sync_det_i) next_st_two[RIS_B_SYNC] = 1'b1;
    else if (pkt_done_i) next_st_two[RIS_B_SYNC] = 1'b0;
    if (pre_det_i) next_st_two[RIS_B_PRE_OK] = 1'b1;
    else if (sync_det_i || sync_timeout_i) next_st_two[RIS_B_PRE_OK] = 1'b0;
    next_st_two[RIS_B_PRE_BAD] = pre_bad_i; // self-clearing pulse
    next_st_two[RIS_B_RSSI]    = rssi_above_i;
    next_st_two[RIS_B_WAKE]    = wake_expire_i; // pulse, not a status
    // latched even when masked; a later enable still fires on the pending copy
    if (lowbat_i) next_st_two[RIS_B_LOWBAT] = 1'b1;
    else if (rd_two && en_two[RIS_B_LOWBAT]) next_st_two[RIS_B_LOWBAT] = 1'b0;
    next_st_two[RIS_B_READY] = chip_ready;
    if (por_i) next_st_two[RIS_B_POR] = 1'b1;
    else if (rd_two && en_two[RIS_B_POR]) next_st_two[RIS_B_POR] = 1'b0;
  end

  // only enabled rises arm a pending flag; masked bits stay plain status,
  // except low battery, whose rise is kept so a later enable still fires
  assign src_two = rise_two & (en_two | (8'h01 << RIS_B_LOWBAT));

  // pending interrupt flags; a new event in the read cycle beats the clear
  always_comb begin
    next_pend_two = pend_two;
    if (rd_two) next_pend_two = pend_two & ~en_two;
    next_pend_two = next_pend_two | src_two;
    next_st_one   = st_one;
    if (rd_one) next_st_one = st_one & ~en_one;
    next_st_one = next_st_one | rise_one;
  end

  assign pend_any = |(pend_two & en_two) | |(st_one & en_one);

  // pin low when anything enabled is pending; read of status two releases it unless a first-group flag or a new enabled rise is pending
  always_comb begin
    next_irq_low = pend_any;
    if (rd_two && ~|(st_one & en_one) && ~|(src_two & en_two)) next_irq_low = 1'b0;
  end

  // read data, registered; view of status two shows pending or live level
  always_comb begin
    next_rdata = reg_rdata_o;
    if (ce_i && reg_rd_i) begin
      case (reg_addr_i)
        RIS_OFS_STATUS_ONE: next_rdata = st_one;
        RIS_OFS_STATUS_TWO: next_rdata = (pend_two & en_two) | (st_two & ~en_two);
        RIS_OFS_ENABLE_ONE: next_rdata = en_one;
        RIS_OFS_ENABLE_TWO: next_rdata = en_two;
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      en_one      <= RIS_EN_ONE_RST;
      en_two_w    <= RIS_EN_TWO_RST;
      st_two      <= RIS_STATUS_RST;
      pend_two    <= RIS_STATUS_RST;
      st_one      <= 8'h00;
      irq_low     <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      en_one      <= next_en_one;
      en_two_w    <= next_en_two_w;
      st_two      <= next_st_two;
      pend_two    <= next_pend_two;
      st_one      <= next_st_one;
      irq_low     <= next_irq_low;
      reg_rdata_o <= next_rdata;
    end
  end

  assign interrupt_request_low_o = ~irq_low;

  // a low battery event is latched into status two on the next edge, masked or not
  a_lowbat_latch: assert property (@(posedge mclk_i) disable iff (srst_i)
    ce_i && lowbat_i |=> st_two[RIS_B_LOWBAT]) else $error("low battery not latched");

  a_pin_pending: assert property (@(posedge mclk_i) disable iff (srst_i)
    ce_i && !rd_two && pend_any |=> !interrupt_request_low_o) else $error("pin high with pending flag");

  a_ro_enables: assert property (@(posedge mclk_i) disable iff (srst_i)
    en_two[7:5] == {3{pre_det_mode_i}}) else $error("read-only enables follow host");

  a_sync_rise: assert property (@(posedge mclk_i) disable iff (srst_i)
    ce_i && sync_det_i |=> st_two[RIS_B_SYNC] && !st_two[RIS_B_PRE_OK]) else $error("sync flags wrong");

  a_pre_rise: assert property (@(posedge mclk_i) disable iff (srst_i)
    ce_i && pre_det_i |=> st_two[RIS_B_PRE_OK]) else $error("preamble flag not set");

  a_rssi_follow: assert property (@(posedge mclk_i) disable iff (srst_i)
    ce_i |=> st_two[RIS_B_RSSI] == $past(rssi_above_i)) else $error("rssi flag not following");

  a_read_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_two && !src_two[RIS_B_WAKE] && en_two[RIS_B_WAKE] |=> !pend_two[RIS_B_WAKE]) else $error("wake not cleared");

  a_masked_keep: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_two && !en_two[RIS_B_POR] && st_two[RIS_B_POR] |=> st_two[RIS_B_POR]) else $error("masked flag cleared");

  a_group_one: assert property (@(posedge mclk_i) disable iff (srst_i)
    ce_i && |(rise_one & en_one) ##1 ce_i |=> !interrupt_request_low_o) else $error("group one not gated");

  // rise arms the pending flag one edge later, the pin follows one edge after that
  a_edge_pin: assert property (@(posedge mclk_i) disable iff (srst_i)
    ce_i && |(rise_two & en_two) && !rd_two ##1 ce_i && !rd_two
    |=> !interrupt_request_low_o) else $error("rise missed");
endmodule

// *** verification/ris_radio_model.sv ***
// radio event source model: one-cycle event pulses toward the interrupt block
`timescale 1ns/1ps
module ris_radio_model (
  input  wire logic       mclk_i,
  output logic      [7:0] evt_o
);
  // bit order: sync, pkt done, preamble, sync timeout, bad preamble, wake, low battery, power-on
  initial begin
    evt_o = 8'h00;
  end
  // bad preamble and wake expiry only ever pulse, never hold as status
  task automatic pulse(input logic [7:0] m);
    @(posedge mclk_i);
    #1 evt_o = m;
    @(posedge mclk_i);
    #1 evt_o = 8'h00;
  endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench for the radio interrupt status and enable block
`timescale 1ns/1ps
module tb;
  import ris_pkg::*;
  logic       mclk, srst, ce, rd, wr, mode, rssi, xtal, irq_n;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, g1, evt, v;
  int         errors, checks;

  always #50 mclk = ~mclk;

  // settle count shortened so the ready flag comes within a few cycles
  ris_irq #(.SETTLE_CYC(4)) u_ris_irq (.mclk_i(mclk), .srst_i(srst), .ce_i(ce), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pre_det_mode_i(mode),
    .sync_det_i(evt[0]), .pkt_done_i(evt[1]), .pre_det_i(evt[2]), .sync_timeout_i(evt[3]),
    .pre_bad_i(evt[4]), .rssi_above_i(rssi), .wake_expire_i(evt[5]), .lowbat_i(evt[6]),
    .xtal_on_i(xtal), .por_i(evt[7]), .group_one_evt_i(g1), .interrupt_request_low_o(irq_n));

  ris_radio_model u_ris_radio_model (.mclk_i(mclk), .evt_o(evt));

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask

  // strobes go up just after an edge and drop after the sampling edge
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge mclk);
    #1 wr = 1'b0;
  endtask

  // read data is registered, so it is valid once the sampling edge has passed
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string n);
    @(posedge mclk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge mclk);
    #1 rd = 1'b0;
    v = rdata;
    chk(n, v, e);
  endtask

  // bounded wait for the pin level; running out ends the run
  task automatic wait_pin(input logic e);
    for (int k = 0; k < 12 && irq_n !== e; k++) begin
      @(posedge mclk);
      #1;
    end
    chk("irq_pin", {7'h00, irq_n}, {7'h00, e});
    if (irq_n !== e) finish_test();
  endtask

  initial begin
    mclk = 0; srst = 1; ce = 1; rd = 0; wr = 0; mode = 0; rssi = 0; xtal = 0;
    addr = 7'h00; wdata = 8'h00; g1 = 8'h00; errors = 0; checks = 0;
    repeat (12) @(posedge mclk);
    #1 srst = 0;
    // reset state: enables clear, only power-on status set, pin idle high
    rd_chk(RIS_OFS_ENABLE_ONE, 8'h00, "enable_one");
    rd_chk(RIS_OFS_ENABLE_TWO, 8'h00, "enable_two");
    rd_chk(RIS_OFS_STATUS_TWO, 8'h01, "status_two");
    wait_pin(1'b1);
    rd_chk(7'h07, 8'h00, "unmapped");
    // clock enable low freezes the block: the write is lost
    ce = 1'b0;
    wr_reg(RIS_OFS_ENABLE_ONE, 8'h5a);
    ce = 1'b1;
    rd_chk(RIS_OFS_ENABLE_ONE, 8'h00, "enable_one");
    // top three enable bits ignore writes and follow the detect mode
    wr_reg(RIS_OFS_ENABLE_TWO, 8'hff);
    rd_chk(RIS_OFS_ENABLE_TWO, 8'h1f, "enable_two");
    mode = 1'b1;
    rd_chk(RIS_OFS_ENABLE_TWO, 8'hff, "enable_two");
    mode = 1'b0;
    // low battery latched while masked, interrupts once enabled
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h00);
    u_ris_radio_model.pulse(8'h40);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h05, "status_two");
    rd_chk(RIS_OFS_STATUS_TWO, 8'h05, "status_two");
    chk("irq_pin", {7'h00, irq_n}, 8'h01);
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h04);
    wait_pin(1'b0);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h05, "status_two");
    wait_pin(1'b1);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h01, "status_two");
    // wake expiry as an enabled source
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h08);
    u_ris_radio_model.pulse(8'h20);
    wait_pin(1'b0);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h09, "status_two");
    wait_pin(1'b1);
    // bad preamble enabled by the detect mode alone
    mode = 1'b1;
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h00);
    u_ris_radio_model.pulse(8'h10);
    wait_pin(1'b0);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h21, "status_two");
    wait_pin(1'b1);
    mode = 1'b0;
    // preamble then sync then packet end, and preamble then sync timeout
    u_ris_radio_model.pulse(8'h04);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h41, "status_two");
    u_ris_radio_model.pulse(8'h01);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h81, "status_two");
    u_ris_radio_model.pulse(8'h02);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h01, "status_two");
    u_ris_radio_model.pulse(8'h04);
    u_ris_radio_model.pulse(8'h08);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h01, "status_two");
    // signal strength: live while masked, pending once enabled
    rssi = 1'b1;
    rd_chk(RIS_OFS_STATUS_TWO, 8'h11, "status_two");
    rssi = 1'b0;
    rd_chk(RIS_OFS_STATUS_TWO, 8'h01, "status_two");
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h10);
    rssi = 1'b1;
    wait_pin(1'b0);
    rssi = 1'b0;
    rd_chk(RIS_OFS_STATUS_TWO, 8'h11, "status_two");
    wait_pin(1'b1);
    // chip ready after the settle count, gone again at idle
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h02);
    xtal = 1'b1;
    wait_pin(1'b0);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h03, "status_two");
    wait_pin(1'b1);
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h00);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h03, "status_two");
    xtal = 1'b0;
    // idle reaches the settle timer, then the status copy, one edge each
    repeat (2) @(posedge mclk);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h01, "status_two");
    // power-on event enabled
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h01);
    u_ris_radio_model.pulse(8'h80);
    wait_pin(1'b0);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h01, "status_two");
    wait_pin(1'b1);
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h00);
    // each first-group source alone: enabled lowers the pin, masked leaves it high
    for (int i = 0; i < 8; i++) begin
      wr_reg(RIS_OFS_ENABLE_ONE, 8'h01 << i);
      g1 = 8'h01 << i;
      wait_pin(1'b0);
      g1 = 8'h00;
      rd_chk(RIS_OFS_ENABLE_ONE, 8'h01 << i, "enable_one");
      rd_chk(RIS_OFS_STATUS_ONE, 8'h01 << i, "status_one");
      wait_pin(1'b1);
      wr_reg(RIS_OFS_ENABLE_ONE, ~(8'h01 << i));
      g1 = 8'h01 << i;
      repeat (4) @(posedge mclk);
      #1 chk("irq_pin", {7'h00, irq_n}, 8'h01);
      g1 = 8'h00;
      // the masked event stays latched; enable it and read to clear it
      wr_reg(RIS_OFS_ENABLE_ONE, 8'hff);
      rd_chk(RIS_OFS_STATUS_ONE, 8'h01 << i, "status_one");
      wait_pin(1'b1);
    end
    // a pending first-group source keeps the pin low across a second-group read
    wr_reg(RIS_OFS_ENABLE_ONE, 8'h01);
    wr_reg(RIS_OFS_ENABLE_TWO, 8'h08);
    g1 = 8'h01;
    wait_pin(1'b0);
    g1 = 8'h00;
    u_ris_radio_model.pulse(8'h20);
    rd_chk(RIS_OFS_STATUS_TWO, 8'h08, "status_two");
    repeat (3) @(posedge mclk);
    #1 chk("irq_pin", {7'h00, irq_n}, 8'h00);
    rd_chk(RIS_OFS_STATUS_ONE, 8'h01, "status_one");
    wait_pin(1'b1);
    finish_test();
  end
endmodule
